/* File: verilog/sbpr_top.sv */
// serial parameter-read engine of the discoverable parameter store
// Notes on behaviour
// [RULE1] byte 30h bits 1:0 read 01b; byte 31h reads 20h, the 4 KB erase opcode
// [RULE2] byte 30h bit 2 reads 1, write granularity 64 bytes or more
// [RULE3] byte 30h bit 3 reads 0, whole byte reads E5h
// [RULE4] byte 30h bit 4 reads 0, selecting opcode 50h for volatile writes
// [RULE5] byte 30h bits 7:5 always read 111b, never changeable
// [RULE6] byte 32h bit 0 reads 1, 1-1-2 fast read supported
// [RULE7] bits 18:17 read 00b, three-byte addressing only
// [RULE8] bits 19 to 22 read 0, bit 23 reads 1; 32h is 81h, 33h is FFh
// [RULE9] byte 38h reads 00h, byte 39h reads FFh for 1-4-4 read
// [RULE10] byte 3Ah reads 00h, byte 3Bh reads FFh for 1-1-4 read
// [RULE11] chip select low, 5Ah, three address bytes, dummy byte, then data until deselect
// [RULE12] header pointer at 0Ch to 0Eh names 30h as table start
// [RULE13] bytes 34h to 37h hold density word 001FFFFFh, little endian
// [RULE14] consecutive bytes at incrementing addresses, each most significant bit first
`timescale 1ns/1ns
module sbpr_top
   import sbpr_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic sclk_i,
   input  wire logic csn_i,
   input  wire logic si_i,
   output logic      so_o,
   output logic      so_oe_n_o,
   output logic      read_active_o
);

   typedef enum logic [2:0] {
      SBPR_CMD    = 3'b000,
      SBPR_ADDR   = 3'b001,
      SBPR_DUMMY  = 3'b010,
      SBPR_DATA   = 3'b011,
      SBPR_IGNORE = 3'b100
   } sbpr_state_t;

   // ****************************************
   // helpers
   // ****************************************
   // true when the bit now being sampled is the last of a field
   function automatic logic last_bit(input logic [4:0] cnt, input logic [4:0] len);
      last_bit = (cnt == (len - 5'h01));
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   sbpr_state_t state;
   logic        sclk_q;
   logic        sclk_rise;
   logic        sclk_fall;
   logic [4:0]  bit_cnt;
   logic [23:0] shift_in;
   logic [23:0] next_shift_in;
   logic [23:0] fetch_addr;
   logic        fetch_on;
   logic [7:0]  table_byte;
   logic [7:0]  out_sh;
   logic [2:0]  out_cnt;
   logic        driving;
   logic        need_byte;

   sbpr_byte_if fetch_if ();
   sbpr_byte_if send_if ();

   // ****************************************
   // serial clock edges
   // ****************************************
   // pins are synchronous to clk_i, so a single delay stage finds the edges
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_q <= 1'h0;
      end else begin
         sclk_q <= sclk_i;
      end
   end

   assign sclk_rise     = sclk_i & ~sclk_q & ~csn_i;
   assign sclk_fall     = ~sclk_i & sclk_q & ~csn_i;
   assign next_shift_in = {shift_in[22:0], si_i};

   // ****************************************
   // command, address and dummy phases
   // ****************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= SBPR_CMD;
      end else if (csn_i) begin
         // deselect may come at any time and ends the read at once
         state <= SBPR_CMD; // RULE11
      end else if (sclk_rise) begin
         case (state)
            SBPR_CMD: begin
               if (last_bit(bit_cnt, CMD_BITS)) begin
                  if (next_shift_in[7:0] == CMD_PARAM_TABLE_READ) begin
                     state <= SBPR_ADDR; // RULE11
                  end else begin
                     // other commands are not this block's business
                     state <= SBPR_IGNORE;
                  end
               end
            end
            SBPR_ADDR: begin
               if (last_bit(bit_cnt, ADDR_BITS)) begin
                  state <= SBPR_DUMMY; // RULE11
               end
            end
            SBPR_DUMMY: begin
               if (last_bit(bit_cnt, DUMMY_BITS)) begin
                  state <= SBPR_DATA; // RULE11
               end
            end
            SBPR_DATA:   state <= SBPR_DATA;
            SBPR_IGNORE: state <= SBPR_IGNORE;
            default:     state <= SBPR_CMD;
         endcase
      end
   end

   // bit counter restarts at every phase boundary
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bit_cnt <= 5'h00;
      end else if (csn_i) begin
         bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
         case (state)
            SBPR_CMD:   bit_cnt <= last_bit(bit_cnt, CMD_BITS)   ? 5'h00 : bit_cnt + 5'h01;
            SBPR_ADDR:  bit_cnt <= last_bit(bit_cnt, ADDR_BITS)  ? 5'h00 : bit_cnt + 5'h01;
            SBPR_DUMMY: bit_cnt <= last_bit(bit_cnt, DUMMY_BITS) ? 5'h00 : bit_cnt + 5'h01;
            default:    bit_cnt <= 5'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         shift_in <= 24'h000000;
      end else if (sclk_rise) begin
         shift_in <= next_shift_in;
      end
   end

   // ****************************************
   // table fetch into the buffer
   // ****************************************
   // prefetch starts during the dummy byte so the first byte is ready in time
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fetch_on   <= 1'h0;
         fetch_addr <= 24'h000000;
      end else if (csn_i) begin
         fetch_on   <= 1'h0;
      end else if (sclk_rise && state == SBPR_ADDR && last_bit(bit_cnt, ADDR_BITS)) begin
         fetch_on   <= 1'h1;
         fetch_addr <= next_shift_in;
      end else if (fetch_if.valid && fetch_if.ready) begin
         // address wraps at the top of the 24-bit space
         fetch_addr <= fetch_addr + 24'h000001; // RULE14
      end
   end

   sbpr_table sbpr_table_i (
      .addr_i (fetch_addr),
      .data_o (table_byte)
   );

   assign fetch_if.valid = fetch_on;
   assign fetch_if.data  = table_byte;

   sbpr_skid sbpr_skid_i (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .flush_i (csn_i),
      .in_if   (fetch_if),
      .out_if  (send_if)
   );

   // ****************************************
   // serial output
   // ****************************************
   assign need_byte     = sclk_fall && state == SBPR_DATA && out_cnt == 3'h0;
   assign send_if.ready = need_byte;

   // new bits appear on falling edges so the host samples on rising ones
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_sh  <= 8'h00;
         out_cnt <= 3'h0;
      end else if (csn_i) begin
         out_cnt <= 3'h0;
      end else if (need_byte) begin
         // buffer runs far ahead of sclk; an empty buffer reads as unused
         out_sh  <= send_if.valid ? send_if.data : UNMAPPED_BYTE; // RULE14
         out_cnt <= 3'h1;
      end else if (sclk_fall && state == SBPR_DATA) begin
         out_sh  <= {out_sh[6:0], 1'h0}; // RULE14
         out_cnt <= (out_cnt == DATA_BITS_LAST) ? 3'h0 : out_cnt + 3'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         driving <= 1'h0;
      end else if (csn_i) begin
         driving <= 1'h0; // RULE11
      end else if (need_byte) begin
         driving <= 1'h1;
      end
   end

   assign so_o          = out_sh[7]; // RULE14
   assign so_oe_n_o     = ~driving;
   assign read_active_o = driving;

endmodule

/* File: inc/sbpr_pkg.sv */
// constants of the discoverable parameter store
package sbpr_pkg;

   // ****************************************
   // serial command framing
   // ****************************************
   localparam logic [7:0]  CMD_PARAM_TABLE_READ = 8'h5A;
   localparam logic [4:0]  CMD_BITS             = 5'h08;
   localparam logic [4:0]  ADDR_BITS            = 5'h18;
   localparam logic [4:0]  DUMMY_BITS           = 5'h08;
   localparam logic [2:0]  DATA_BITS_LAST       = 3'h7;
   localparam logic [7:0]  UNMAPPED_BYTE        = 8'hFF;

   // ****************************************
   // header pointer to the basic table
   // ****************************************
   localparam logic [23:0] TABLE_START_PTR      = 24'h000030;
   localparam logic [23:0] PTR_ADDR_B0          = 24'h00000C;
   localparam logic [23:0] PTR_ADDR_B1          = 24'h00000D;
   localparam logic [23:0] PTR_ADDR_B2          = 24'h00000E;

   // ****************************************
   // byte addresses of the basic table
   // ****************************************
   localparam logic [23:0] ADDR_ERASE_CAPS      = 24'h000030;
   localparam logic [23:0] ADDR_ERASE_OPCODE    = 24'h000031;
   localparam logic [23:0] ADDR_READ_CAPS       = 24'h000032;
   localparam logic [23:0] ADDR_READ_CAPS_HI    = 24'h000033;
   localparam logic [23:0] ADDR_DENSITY_B0      = 24'h000034;
   localparam logic [23:0] ADDR_DENSITY_B1      = 24'h000035;
   localparam logic [23:0] ADDR_DENSITY_B2      = 24'h000036;
   localparam logic [23:0] ADDR_DENSITY_B3      = 24'h000037;
   localparam logic [23:0] ADDR_Q144_TIMING     = 24'h000038;
   localparam logic [23:0] ADDR_Q144_OPCODE     = 24'h000039;
   localparam logic [23:0] ADDR_Q114_TIMING     = 24'h00003A;
   localparam logic [23:0] ADDR_Q114_OPCODE     = 24'h00003B;

   // ****************************************
   // field values
   // ****************************************
   localparam logic [1:0]  ERASE_4K_AVAIL       = 2'h1;
   localparam logic        WRITE_GRAN_64        = 1'h1;
   localparam logic        VOL_WREN_REQUIRED    = 1'h0;
   localparam logic        VOL_WREN_OPC_SEL     = 1'h0;
   localparam logic [2:0]  ERASE_BYTE_UNUSED    = 3'h7;
   localparam logic [7:0]  ERASE_4K_OPCODE      = 8'h20;
   localparam logic        FAST_READ_112        = 1'h1;
   localparam logic [1:0]  ADDR_MODE_3BYTE      = 2'h0;
   localparam logic        DTR_SUPPORT          = 1'h0;
   localparam logic        FAST_READ_122        = 1'h0;
   localparam logic        FAST_READ_144        = 1'h0;
   localparam logic        FAST_READ_114        = 1'h0;
   localparam logic        READ_CAPS_UNUSED     = 1'h1;
   localparam logic [7:0]  READ_CAPS_HI_UNUSED  = 8'hFF;
   localparam logic [31:0] DENSITY_WORD         = 32'h001FFFFF;
   localparam logic [4:0]  NO_WAIT_STATES       = 5'h00;
   localparam logic [2:0]  NO_MODE_BITS         = 3'h0;
   localparam logic [7:0]  ABSENT_OPCODE        = 8'hFF;

endpackage

/* File: inc/sbpr_byte_if.sv */
// byte stream with valid and ready between the store's own modules
`timescale 1ns/1ns
interface sbpr_byte_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: verilog/sbpr_table.sv */
// fixed contents of the parameter store, looked up by byte address
`timescale 1ns/1ns
module sbpr_table
   import sbpr_pkg::*;
(
   input  wire logic [23:0] addr_i,
   output logic      [7:0]  data_o
);

   // ****************************************
   // table lookup
   // ****************************************
   always_comb begin
      case (addr_i)
         PTR_ADDR_B0:       data_o = TABLE_START_PTR[7:0];   // RULE12
         PTR_ADDR_B1:       data_o = TABLE_START_PTR[15:8];  // RULE12
         PTR_ADDR_B2:       data_o = TABLE_START_PTR[23:16]; // RULE12
         ADDR_ERASE_CAPS:   data_o = {ERASE_BYTE_UNUSED,     // RULE5
                                      VOL_WREN_OPC_SEL,      // RULE4
                                      VOL_WREN_REQUIRED,     // RULE3
                                      WRITE_GRAN_64,         // RULE2
                                      ERASE_4K_AVAIL};       // RULE1
         ADDR_ERASE_OPCODE: data_o = ERASE_4K_OPCODE;        // RULE1
         ADDR_READ_CAPS:    data_o = {READ_CAPS_UNUSED,      // RULE8
                                      FAST_READ_114,
                                      FAST_READ_144,
                                      FAST_READ_122,
                                      DTR_SUPPORT,
                                      ADDR_MODE_3BYTE,       // RULE7
                                      FAST_READ_112};        // RULE6
         ADDR_READ_CAPS_HI: data_o = READ_CAPS_HI_UNUSED;    // RULE8
         ADDR_DENSITY_B0:   data_o = DENSITY_WORD[7:0];      // RULE13
         ADDR_DENSITY_B1:   data_o = DENSITY_WORD[15:8];     // RULE13
         ADDR_DENSITY_B2:   data_o = DENSITY_WORD[23:16];    // RULE13
         ADDR_DENSITY_B3:   data_o = DENSITY_WORD[31:24];    // RULE13
         ADDR_Q144_TIMING:  data_o = {NO_MODE_BITS, NO_WAIT_STATES}; // RULE9
         ADDR_Q144_OPCODE:  data_o = ABSENT_OPCODE;          // RULE9
         ADDR_Q114_TIMING:  data_o = {NO_MODE_BITS, NO_WAIT_STATES}; // RULE10
         ADDR_Q114_OPCODE:  data_o = ABSENT_OPCODE;          // RULE10
         // bytes outside this part of the table read as unused
         default:           data_o = UNMAPPED_BYTE;
      endcase
   end

endmodule

/* File: verilog/sbpr_skid.sv */
// two-entry buffer between table fetch and serial shifter
`timescale 1ns/1ns
module sbpr_skid
   import sbpr_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic flush_i,
   sbpr_byte_if.snk  in_if,
   sbpr_byte_if.src  out_if
);

   logic [7:0] mem [2];
   logic       wr_ptr;
   logic       rd_ptr;
   logic [1:0] count;
   logic       push;
   logic       pop;

   assign in_if.ready  = (count != 2'h2);
   assign out_if.valid = (count != 2'h0);
   assign out_if.data  = mem[rd_ptr];
   assign push         = in_if.valid & in_if.ready;
   assign pop          = out_if.valid & out_if.ready;

   // ****************************************
   // storage
   // ****************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem[0] <= 8'h00;
         mem[1] <= 8'h00;
      end else if (push) begin
         mem[wr_ptr] <= in_if.data;
      end
   end

   // ****************************************
   // pointers and fill level
   // ****************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr <= 1'h0;
         rd_ptr <= 1'h0;
         count  <= 2'h0;
      end else if (flush_i) begin
         // stale prefetch must not leak into the next frame
         wr_ptr <= 1'h0;
         rd_ptr <= 1'h0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         case ({push, pop})
            2'b10:   count <= count + 2'h1;
            2'b01:   count <= count - 2'h1;
            default: count <= count;
         endcase
      end
   end

endmodule

/* File: dv/sbpr_top_sva.sv */
// concurrent checks on the serial pins of the parameter store
`timescale 1ns/1ns
module sbpr_top_sva (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic sclk_i,
   input wire logic csn_i,
   input wire logic si_i,
   input wire logic so_o,
   input wire logic so_oe_n_o,
   input wire logic read_active_o
);
   logic       sclk_q;
   logic [5:0] rises;
   logic [7:0] cmd_sh;

   // ********
   // rises seen in this frame and the command they carried
   // ********
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_q <= 1'b0;
         rises  <= 6'h0;
         cmd_sh <= 8'h0;
      end else begin
         sclk_q <= sclk_i;
         if (csn_i) begin
            rises <= 6'h0;
         end else if (sclk_i && !sclk_q && rises != 6'h3F) begin
            rises <= rises + 6'h1;
            if (rises < 6'h08) begin
               cmd_sh <= {cmd_sh[6:0], si_i};
            end
         end
      end
   end

   sequence sclk_held_high;
      sclk_i ##1 sclk_i;
   endsequence

   sequence deselected;
      !csn_i ##1 csn_i;
   endsequence

   pair_track_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      read_active_o == !so_oe_n_o) else $error("status and enable differ");
   deselect_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      deselected |=> so_oe_n_o) else $error("output kept after deselect");
   enable_after_fall_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $fell(so_oe_n_o) |-> !$past(sclk_i) && $past(sclk_i, 2) && !$past(csn_i))
      else $error("output enabled without a clock fall");
   enable_on_time_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (rises == 6'h28 && cmd_sh == 8'h5A && !csn_i && sclk_q && !sclk_i) |=> !so_oe_n_o)
      else $error("output late after dummy byte");
   so_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      sclk_held_high ##0 read_active_o |=> (!read_active_o || $stable(so_o)))
      else $error("data bit changed without a clock fall");
   forty_rises_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $fell(so_oe_n_o) |-> rises == 6'h28) else $error("data phase at wrong bit count");
   cmd_match_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $fell(so_oe_n_o) |-> cmd_sh == 8'h5A) else $error("data for a foreign command");
   stay_on_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      read_active_o && !csn_i |=> read_active_o) else $error("output dropped while selected");
   reset_quiet_a: assert property (@(posedge clk_i)
      !rstn_i |-> so_oe_n_o && !read_active_o && !so_o) else $error("outputs active in reset");
endmodule

bind sbpr_top sbpr_top_sva sbpr_top_sva_i (
   .clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk_i), .csn_i(csn_i), .si_i(si_i),
   .so_o(so_o), .so_oe_n_o(so_oe_n_o), .read_active_o(read_active_o));

/* File: dv/sbpr_host.sv */
// host controller model that issues serial read frames
`timescale 1ns/1ns
module sbpr_host (
   input  wire logic clk_i,
   input  wire logic so_i,
   output logic      sclk_o,
   output logic      csn_o,
   output logic      si_o
);
   logic [7:0] rx [16];
   int         ph = 2;

   initial begin
      sclk_o = 1'b0;
      csn_o  = 1'b1;
      si_o   = 1'b0;
   end

   // ********
   // one byte, msb first; nb below 8 stops mid-byte
   // ********
   // ph sets the clock phase length, 2 or more, so a slow host stalls the buffer
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] d);
      d = 8'hFF;
      for (int i = 7; i > 7 - nb; i--) begin
         @(posedge clk_i);
         sclk_o <= 1'b0;
         si_o   <= tx[i];
         repeat (ph + 1) @(posedge clk_i);
         @(negedge clk_i);
         d[i] = so_i;
         @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (ph - 1) @(posedge clk_i);
      end
   endtask

   task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int n,
                        input int tail);
      logic [7:0] d;
      @(posedge clk_i);
      csn_o <= 1'b0;
      xfer(cmd, 8, d);
      for (int b = 2; b >= 0; b--)
         xfer(addr[8*b +: 8], 8, d);
      xfer(8'h00, 8, d);
      for (int k = 0; k < n; k++)
         xfer(8'hFF, 8, rx[k]);
      if (tail > 0)
         xfer(8'hFF, tail, d);
      @(posedge clk_i);
      sclk_o <= 1'b0;
      @(posedge clk_i);
      csn_o <= 1'b1;
      si_o  <= ~si_o;
      repeat (2) @(posedge clk_i);
   endtask
endmodule

/* File: dv/sbpr_top_tb_top.sv */
// self-checking bench of the parameter store serial read
`timescale 1ns/1ns
module sbpr_top_tb_top
   import sbpr_pkg::*;
;
   logic clk_i   = 1'b0;
   logic rstn_i  = 1'b1;
   logic so_last = 1'b0;
   logic seen_active = 1'b0;
   logic sclk_i, csn_i, si_i, so_o, so_oe_n_o, read_active_o, so_line;
   logic [7:0] r [16];
   int mismatches  = 0;
   int checks_done = 0;
   int cycles      = 0;

   always #5 clk_i = ~clk_i;

   sbpr_top sbpr_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk_i), .csn_i(csn_i),
      .si_i(si_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o), .read_active_o(read_active_o));
   sbpr_host sbpr_host_i (.clk_i(clk_i), .so_i(so_line), .sclk_o(sclk_i), .csn_o(csn_i),
      .si_o(si_i));

   // released line shows the inverse of the last driven bit
   assign so_line = so_oe_n_o ? ~so_last : so_o;

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (!so_oe_n_o)
         so_last <= so_o;
      if (read_active_o === 1'b1)
         seen_active <= 1'b1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end

   // ********
   // comparison and closing
   // ********
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic rd(input logic [7:0] cmd, input logic [23:0] a, input int n, input int t);
      sbpr_host_i.frame(cmd, a, n, t);
      r = sbpr_host_i.rx;
   endtask

   // ********
   // scenarios
   // ********
   task automatic walk_table();
      rd(CMD_PARAM_TABLE_READ, 24'h000030, 12, 0);
      chk("erase size", r[0][1:0], 32'h1);
      chk("erase opcode", r[1], 32'h20);
      chk("granularity", r[0][2], 32'h1);
      chk("caps byte", r[0], 32'hE5);
      chk("wren select", r[0][4], 32'h0);
      chk("fixed ones", r[0][7:5], 32'h7);
      chk("dual read", r[2][0], 32'h1);
      chk("addr bytes", r[2][2:1], 32'h0);
      chk("read caps", {r[3], r[2]}, 32'hFF81);
      chk("quad io read", {r[9], r[8]}, 32'hFF00);
      chk("quad out read", {r[11], r[10]}, 32'hFF00);
      chk("density", {r[7], r[6], r[5], r[4]}, 32'h200000 - 32'h1);
   endtask

   task automatic pointer();
      rd(CMD_PARAM_TABLE_READ, 24'h00000C, 3, 0);
      chk("start pointer", {r[2], r[1], r[0]}, 32'h30);
   endtask

   task automatic slow_cross();
      sbpr_host_i.ph = 5;
      rd(CMD_PARAM_TABLE_READ, 24'h00002F, 3, 0);
      sbpr_host_i.ph = 2;
      chk("across start", {r[1], r[2]}, 32'hE520);
   endtask

   task automatic abort_resume();
      rd(CMD_PARAM_TABLE_READ, 24'h000030, 1, 4);
      rd(CMD_PARAM_TABLE_READ, 24'h000031, 2, 0);
      chk("after abort", {r[0], r[1]}, 32'h2081);
   endtask

   task automatic refused();
      seen_active = 1'b0;
      rd(8'h03, 24'h000030, 2, 0);
      chk("drive on foreign cmd", seen_active, 32'h0);
      rd(CMD_PARAM_TABLE_READ, 24'h00003A, 2, 0);
      chk("next frame", {r[0], r[1]}, 32'h00FF);
   endtask

   initial begin
      // a real falling edge before the first clock, so no flop is unknown at the first check
      #1 rstn_i = 1'b0;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      walk_table();
      pointer();
      slow_cross();
      abort_resume();
      refused();
      give_verdict();
   end
endmodule
